// ### core/nsrs_pkg.sv
package nsrs_pkg;

    // ****************************************************************
    // Flash command codes
    // ****************************************************************
    localparam logic [7:0] CMD_RESET     = 8'hFF;
    localparam logic [7:0] CMD_STATUS    = 8'h70;
    localparam logic [7:0] CMD_SIGNATURE = 8'h90;
    localparam logic [7:0] CMD_READ_A    = 8'h00;
    localparam logic [7:0] ADDR_SIG      = 8'h00;

    // ****************************************************************
    // Status byte field positions
    // ****************************************************************
    localparam int ST_UNPROT_BIT = 7;
    localparam int ST_IDLE_BIT   = 6;
    localparam int ST_FAIL_BIT   = 0;

    // ****************************************************************
    // AXI4-Lite register map of the controller
    // ****************************************************************
    localparam logic [3:0] REG_CMD     = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h4;
    localparam logic [3:0] REG_IDENT   = 4'h8;
    localparam logic [3:0] REG_FLASHST = 4'hC;
    localparam int         CMD_OP_LSB  = 0;
    localparam int         CMD_OP_W    = 2;
    localparam logic [1:0] OP_RESET    = 2'h1;
    localparam logic [1:0] OP_STATUS   = 2'h2;
    localparam logic [1:0] OP_IDENT    = 2'h3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ****************************************************************
    // Bus timing: each strobe phase lasts this long
    // ****************************************************************
    localparam int CLK_NS       = 40;
    localparam int STROBE_NS    = 80;
    localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);

    // ****************************************************************
    // Controller states
    // ****************************************************************
    typedef enum logic [3:0] {
        NSRS_IDLE, NSRS_CMD, NSRS_ADDR, NSRS_WAIT_RB, NSRS_RD_MFR,
        NSRS_RD_DEV, NSRS_RD_STAT, NSRS_RESTORE, NSRS_DONE
    } nsrs_state_e;

endpackage

// ### core/nsrs_sync.sv
`timescale 1ns/1ns
`default_nettype none
module nsrs_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         reset,
    // Raw pin and synchronised copy.
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] synced
);

    logic [W-1:0] stage1_q;

    // Two flops; the first is read only by the second.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            stage1_q <= '0;
            synced   <= '0;
        end
        else
        begin
            stage1_q <= raw;
            synced   <= stage1_q;
        end
    end

endmodule
`default_nettype wire

// ### core/nsrs_host.sv
`timescale 1ns/1ns
`default_nettype none
module nsrs_host (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        reset,
    // AXI4-Lite write address, data and response.
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read.
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Flash pins.
    input  wire logic [7:0]  flash_io_in,
    output logic [7:0]       flash_io_out,
    output logic             flash_io_oe,
    output logic             flash_cle,
    output logic             flash_ale,
    output logic             flash_ce_n,
    output logic             flash_re_n,
    output logic             flash_we_n,
    input  wire logic        flash_rb
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [8:0] pins_s;
    nsrs_sync #(.W(9)) u_sync (
        .clk    (clk),
        .reset  (reset),
        .raw    ({flash_rb, flash_io_in}),
        .synced (pins_s)
    );
    logic       rb_s;
    logic [7:0] io_s;
    assign rb_s = pins_s[8];
    assign io_s = pins_s[7:0];

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Page data never passes this block: bad-block marker tests and ECC check bits
    // are left to software, which sees only the status and signature bytes.
    nsrs_pkg::nsrs_state_e state_q;
    logic [3:0]  tmr_q;
    logic        phase_q;
    logic [1:0]  op_q;
    logic        busy_q;
    logic        in_reset_q;
    logic [7:0]  mfr_q;
    logic [7:0]  dev_q;
    logic [7:0]  fstat_q;
    logic        cmd_err_q;
    logic        go;
    logic [1:0]  go_op;
    logic        wr_fire;
    logic        tick;

    // A phase ends after STROBE_CNT cycles, counted from zero.
    assign tick    = (tmr_q == nsrs_pkg::STROBE_CNT - 4'h1);
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign go_op   = s_axi_wdata[nsrs_pkg::CMD_OP_LSB +: nsrs_pkg::CMD_OP_W];
    // A second reset while the device is still in reset is not sent.
    assign go      = wr_fire && !s_axi_awready && s_axi_awaddr == nsrs_pkg::REG_CMD && s_axi_wstrb[0] && !busy_q
                     && go_op != 2'h0 && !(go_op == nsrs_pkg::OP_RESET && in_reset_q);

    // Strobe phase timer: each half of a strobe lasts STROBE_CNT cycles.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            tmr_q <= 4'h0;
        else if (state_q == nsrs_pkg::NSRS_IDLE || tick || state_q == nsrs_pkg::NSRS_WAIT_RB)
            tmr_q <= 4'h0;
        else
            tmr_q <= tmr_q + 4'h1;
    end

    // Main state machine; phase_q low is the active strobe half.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= nsrs_pkg::NSRS_IDLE;
            phase_q <= 1'b0;
            op_q    <= 2'h0;
        end
        else
        begin
            unique case (state_q)
                nsrs_pkg::NSRS_IDLE:
                begin
                    phase_q <= 1'b0;
                    if (go)
                    begin
                        op_q    <= go_op;
                        state_q <= nsrs_pkg::NSRS_CMD;
                    end
                end
                nsrs_pkg::NSRS_CMD:
                    if (tick)
                    begin
                        phase_q <= !phase_q;
                        if (phase_q)
                        begin
                            // Signature takes one address cycle after its single command write.
                            if (op_q == nsrs_pkg::OP_IDENT)
                                state_q <= nsrs_pkg::NSRS_ADDR;
                            else if (op_q == nsrs_pkg::OP_RESET)
                                state_q <= nsrs_pkg::NSRS_WAIT_RB;
                            else
                                state_q <= nsrs_pkg::NSRS_RD_STAT;
                        end
                    end
                nsrs_pkg::NSRS_ADDR:
                    if (tick)
                    begin
                        phase_q <= !phase_q;
                        if (phase_q)
                            state_q <= nsrs_pkg::NSRS_RD_MFR;
                    end
                nsrs_pkg::NSRS_WAIT_RB:
                    // Reset busy length varies, so see the pin fall before waiting for its rise;
                    // the synchroniser lag would otherwise let a stale ready end the wait.
                    if (!rb_s)
                        phase_q <= 1'b1;
                    else if (phase_q)
                    begin
                        phase_q <= 1'b0;
                        state_q <= nsrs_pkg::NSRS_RESTORE;
                    end
                nsrs_pkg::NSRS_RD_MFR, nsrs_pkg::NSRS_RD_DEV:
                    if (tick)
                    begin
                        phase_q <= !phase_q;
                        if (phase_q)
                            state_q <= (state_q == nsrs_pkg::NSRS_RD_MFR) ? nsrs_pkg::NSRS_RD_DEV
                                                                          : nsrs_pkg::NSRS_DONE;
                    end
                nsrs_pkg::NSRS_RD_STAT:
                    if (tick)
                    begin
                        phase_q <= !phase_q;
                        if (phase_q)
                            state_q <= nsrs_pkg::NSRS_RESTORE;
                    end
                nsrs_pkg::NSRS_RESTORE:
                    // Leaving status mode needs a fresh read command.
                    if (tick)
                    begin
                        phase_q <= !phase_q;
                        if (phase_q)
                            state_q <= nsrs_pkg::NSRS_DONE;
                    end
                nsrs_pkg::NSRS_DONE:
                    state_q <= nsrs_pkg::NSRS_IDLE;
                default:
                    state_q <= nsrs_pkg::NSRS_IDLE;
            endcase
        end
    end

    // Busy flag and reset-state tracking.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            busy_q     <= 1'b0;
            in_reset_q <= 1'b0;
        end
        else
        begin
            if (go)
                busy_q <= 1'b1;
            else if (state_q == nsrs_pkg::NSRS_DONE)
                busy_q <= 1'b0;
            // Any other command leaves the reset state.
            if (state_q == nsrs_pkg::NSRS_DONE)
                in_reset_q <= (op_q == nsrs_pkg::OP_RESET);
        end
    end

    // Capture read data at the end of the high half after each read strobe, when the
    // two-flop pin synchroniser has caught up with the byte shown while it was low.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mfr_q   <= 8'h00;
            dev_q   <= 8'h00;
            fstat_q <= 8'h00;
        end
        else if (tick && phase_q)
        begin
            if (state_q == nsrs_pkg::NSRS_RD_MFR)
                mfr_q <= io_s;
            if (state_q == nsrs_pkg::NSRS_RD_DEV)
                dev_q <= io_s;
            // Reserved bits five to one are masked off; the failure bit goes to software,
            // which retires the block or leans on its ECC.
            if (state_q == nsrs_pkg::NSRS_RD_STAT)
                fstat_q <= io_s & (8'h01 << nsrs_pkg::ST_UNPROT_BIT | 8'h01 << nsrs_pkg::ST_IDLE_BIT
                                   | 8'h01 << nsrs_pkg::ST_FAIL_BIT);
        end
    end

    // Pin drive, all registered.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            flash_ce_n   <= 1'b1;
            flash_cle    <= 1'b0;
            flash_ale    <= 1'b0;
            flash_we_n   <= 1'b1;
            flash_re_n   <= 1'b1;
            flash_io_oe  <= 1'b0;
            flash_io_out <= 8'h00;
        end
        else
        begin
            flash_ce_n  <= (state_q == nsrs_pkg::NSRS_IDLE || state_q == nsrs_pkg::NSRS_DONE);
            flash_cle   <= (state_q == nsrs_pkg::NSRS_CMD || state_q == nsrs_pkg::NSRS_RESTORE);
            flash_ale   <= (state_q == nsrs_pkg::NSRS_ADDR);
            flash_we_n  <= !((state_q == nsrs_pkg::NSRS_CMD || state_q == nsrs_pkg::NSRS_ADDR
                             || state_q == nsrs_pkg::NSRS_RESTORE) && !phase_q);
            // Status tracks live, so one read strobe after the command is enough.
            flash_re_n  <= !((state_q == nsrs_pkg::NSRS_RD_MFR || state_q == nsrs_pkg::NSRS_RD_DEV
                             || state_q == nsrs_pkg::NSRS_RD_STAT) && !phase_q);
            flash_io_oe <= (state_q == nsrs_pkg::NSRS_CMD || state_q == nsrs_pkg::NSRS_ADDR
                            || state_q == nsrs_pkg::NSRS_RESTORE);
            unique case (state_q)
                nsrs_pkg::NSRS_ADDR:    flash_io_out <= nsrs_pkg::ADDR_SIG;
                nsrs_pkg::NSRS_RESTORE: flash_io_out <= nsrs_pkg::CMD_READ_A;
                nsrs_pkg::NSRS_CMD:
                    // No erase code exists here, so no bad-block marker is lost before software scans.
                    flash_io_out <= (op_q == nsrs_pkg::OP_RESET)  ? nsrs_pkg::CMD_RESET :
                                    (op_q == nsrs_pkg::OP_STATUS) ? nsrs_pkg::CMD_STATUS
                                                                  : nsrs_pkg::CMD_SIGNATURE;
                default:                flash_io_out <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    // Write: both channels taken together, response one cycle after the hand-off.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= nsrs_pkg::RESP_OKAY;
            cmd_err_q     <= 1'b0;
        end
        else
        begin
            s_axi_awready <= wr_fire && !s_axi_awready;
            s_axi_wready  <= wr_fire && !s_axi_awready;
            if (wr_fire && !s_axi_awready)
            begin
                if (s_axi_awaddr != nsrs_pkg::REG_CMD)
                    s_axi_bresp <= nsrs_pkg::RESP_DECERR;
                else if (!go)
                    s_axi_bresp <= nsrs_pkg::RESP_SLVERR;
                else
                    s_axi_bresp <= nsrs_pkg::RESP_OKAY;
                cmd_err_q <= (s_axi_awaddr == nsrs_pkg::REG_CMD) && !go;
            end
            // The response waits for both hand-offs, so it rises one cycle after the readies.
            if (s_axi_awready)
                s_axi_bvalid <= 1'b1;
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Read: answered one cycle after the hand-off; status shows busy, error and reset state.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= nsrs_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
            begin
                s_axi_rresp  <= nsrs_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    nsrs_pkg::REG_CMD:     s_axi_rdata <= {30'h0, op_q};
                    nsrs_pkg::REG_STATUS:  s_axi_rdata <= {29'h0, cmd_err_q, in_reset_q, busy_q};
                    nsrs_pkg::REG_IDENT:   s_axi_rdata <= {16'h0, dev_q, mfr_q};
                    nsrs_pkg::REG_FLASHST: s_axi_rdata <= {24'h0, fstat_q};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= nsrs_pkg::RESP_DECERR;
                    end
                endcase
            end
            // Data is loaded with the address hand-off and shown one cycle later.
            if (s_axi_arready)
                s_axi_rvalid <= 1'b1;
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ### testbench/nsrs_host_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module nsrs_host_asserts (
    // Clock and reset.
    input wire logic       clk,
    input wire logic       reset,
    // Register bus handshakes.
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    // Flash pins.
    input wire logic [7:0] flash_io_out,
    input wire logic       flash_io_oe,
    input wire logic       flash_ale,
    input wire logic       flash_cle,
    input wire logic       flash_re_n,
    input wire logic       flash_we_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // A command byte latched on the pins: write strobe falls with the latch enable up.
    sequence s_cmd(logic [7:0] code);
        $fell(flash_we_n) && flash_cle && flash_io_out == code;
    endsequence

    AST_WE_PULSE: assert property ($fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
        else $error("write strobe width wrong");
    AST_RE_PULSE: assert property ($fell(flash_re_n) |=> !flash_re_n ##1 flash_re_n)
        else $error("read strobe width wrong");
    AST_NO_CONTENTION: assert property (!(flash_io_oe && !flash_re_n))
        else $error("host drives bus during read");
    AST_IDENT_ADDR: assert property (s_cmd(nsrs_pkg::CMD_SIGNATURE) |->
        ##[1:12] ($fell(flash_we_n) && flash_ale && flash_io_out == nsrs_pkg::ADDR_SIG))
        else $error("identification address missing");
    AST_STATUS_EXIT: assert property (s_cmd(nsrs_pkg::CMD_STATUS) |-> ##[1:40] s_cmd(nsrs_pkg::CMD_READ_A))
        else $error("status mode not left");
    AST_RESET_REREAD: assert property (s_cmd(nsrs_pkg::CMD_RESET) |-> ##[1:400] s_cmd(nsrs_pkg::CMD_READ_A))
        else $error("no read command after reset");
    // Offers that the controller has not taken yet.
    sequence s_wr_offer;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    endsequence
    sequence s_rd_offer;
        s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    endsequence

    AST_W_ANSWER: assert property (s_wr_offer |=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid)
        else $error("write not answered");
    AST_R_ANSWER: assert property (s_rd_offer |=> s_axi_arready ##1 s_axi_rvalid)
        else $error("read not answered");
endmodule
`default_nettype wire

// ### testbench/nsrs_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module nsrs_flash_model #(
    parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value.
    parameter logic [7:0] PART_CODE  = 8'h3C  // Arbitrary value.
) (
    // Timing reference for the busy interval.
    input  wire logic       clk,
    // Pins driven by the controller.
    input  wire logic [7:0] flash_io_out,
    input  wire logic       flash_io_oe,
    input  wire logic       flash_cle,
    input  wire logic       flash_ce_n,
    input  wire logic       flash_re_n,
    input  wire logic       flash_we_n,
    // Knobs set by the testbench.
    input  wire logic       unprotected,
    input  wire logic       op_failed,
    input  wire logic [7:0] busy_cycles,
    // Pins driven by the device.
    output logic [7:0]      flash_io_in,
    output logic            flash_rb
);
    logic [7:0] io_q     = 8'h00;
    logic       cle_q    = 1'b0;
    logic       we_q     = 1'b1;
    logic       re_q     = 1'b1;
    logic [1:0] mode_q   = 2'h0;
    logic [1:0] reads_q  = 2'h0;
    logic [7:0] busy_q   = 8'h00;
    logic [7:0] noise_q  = 8'h00;
    logic       in_rst_q = 1'b0;

    // Latch on the rising write strobe, using values captured while it was low.
    always @(posedge clk)
    begin
        we_q    <= flash_we_n;
        re_q    <= flash_re_n;
        noise_q <= noise_q + 8'h35;
        if (!flash_we_n)
        begin
            io_q  <= flash_io_out;
            cle_q <= flash_cle;
        end
        if (busy_q != 8'h00)
            busy_q <= busy_q - 8'h01;
        if (flash_re_n && !re_q && !flash_ce_n && reads_q != 2'h2)
            reads_q <= reads_q + 2'h1;
        if (flash_we_n && !we_q && !flash_ce_n && cle_q)
        begin
            // While busy only the status code is taken besides reset.
            if (io_q != 8'hFF && (busy_q == 8'h00 || io_q == 8'h70))
            begin
                in_rst_q <= 1'b0;
                reads_q  <= 2'h0;
                mode_q   <= io_q == 8'h70 ? 2'h1 : io_q == 8'h90 ? 2'h2 : 2'h0;
            end
            else if (io_q == 8'hFF && !in_rst_q)
            begin
                busy_q   <= busy_cycles;
                mode_q   <= 2'h0;
                in_rst_q <= 1'b1;
            end
        end
    end

    // Ready while no busy interval runs; a released bus shows a moving pattern.
    assign flash_rb = busy_q == 8'h00;
    always_comb
    begin
        flash_io_in = noise_q;
        if (!flash_ce_n && !flash_re_n && !flash_io_oe)
        begin
            if (mode_q == 2'h1)
                flash_io_in = {unprotected, flash_rb, 5'b10101, op_failed};
            else if (mode_q == 2'h2 && reads_q == 2'h0)
                flash_io_in = MAKER_CODE;
            else if (mode_q == 2'h2 && reads_q == 2'h1)
                flash_io_in = PART_CODE;
        end
    end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam logic [7:0] MAKER = 8'hA5; // Arbitrary value.
    localparam logic [7:0] PART  = 8'h3C; // Arbitrary value.
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        unprotected = 1'b1;
    logic        op_failed = 1'b0;
    logic [7:0]  busy_cycles = 8'h03;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd;
    logic [7:0]  flash_io_in, flash_io_out;
    logic        flash_io_oe, flash_cle, flash_ale, flash_ce_n, flash_re_n, flash_we_n, flash_rb;
    int          fails = 0;
    int          check_count = 0;
    int          k;

    // Controller under test and the flash device it talks to.
    nsrs_host u_nsrs_host (.*);
    nsrs_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_nsrs_flash_model (.*);

    // Free-running clock.
    initial
    begin
        forever #20 clk = ~clk;
    end

    task automatic summarize();
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Each task starts on a fresh edge so no signal is assigned twice in one step.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp);
        int i;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        if (i == 50)
        begin
            fails++;
            summarize();
        end
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, exp});
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        int i;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        if (i == 50)
        begin
            fails++;
            summarize();
        end
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
        axi_rd(a, rd);
        chk(rd & mask, exp);
    endtask

    // Polling is bounded; a controller that never finishes ends the run.
    task automatic run_op(input logic [1:0] o);
        int n;
        axi_wr(nsrs_pkg::REG_CMD, {30'h0, o}, nsrs_pkg::RESP_OKAY);
        for (n = 0; n < 100; n++)
        begin
            axi_rd(nsrs_pkg::REG_STATUS, rd);
            if (rd[0] === 1'b0)
                break;
        end
        if (n == 100)
        begin
            fails++;
            summarize();
        end
    endtask

    // Main sequence.
    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rchk(nsrs_pkg::REG_STATUS, 32'h1, 32'h0);
        axi_wr(nsrs_pkg::REG_IDENT, 32'h0, nsrs_pkg::RESP_DECERR);
        axi_wr(nsrs_pkg::REG_CMD, 32'h0, nsrs_pkg::RESP_SLVERR);
        run_op(nsrs_pkg::OP_IDENT);
        rchk(nsrs_pkg::REG_IDENT, 32'hFFFF, {16'h0, PART, MAKER});
        for (k = 0; k < 2; k++)
        begin
            unprotected <= k[0];
            op_failed   <= ~k[0];
            run_op(nsrs_pkg::OP_STATUS);
            rchk(nsrs_pkg::REG_FLASHST, 32'hFF, {24'h0, k[0], 6'h20, ~k[0]});
        end
        for (k = 0; k < 2; k++)
        begin
            busy_cycles <= (k == 0) ? 8'h28 : 8'h03;
            run_op(nsrs_pkg::OP_STATUS);
            run_op(nsrs_pkg::OP_RESET);
            rchk(nsrs_pkg::REG_STATUS, 32'h7, 32'h2);
            axi_wr(nsrs_pkg::REG_CMD, 32'h1, nsrs_pkg::RESP_SLVERR);
            rchk(nsrs_pkg::REG_STATUS, 32'h7, 32'h6);
            run_op(nsrs_pkg::OP_STATUS);
            rchk(nsrs_pkg::REG_CMD, 32'h3, 32'h2);
        end
        summarize();
    end
endmodule

bind nsrs_host nsrs_host_asserts u_nsrs_host_asserts (.*);
`default_nettype wire
